// ---- core/ee_pkg.sv ----
// Constants, types and command layout for the serial EEPROM command logic
package ee_pkg;

  // ----------------------------------------
  // Instruction encoding
  // ----------------------------------------
  localparam int OPCODE_BITS = 2;
  localparam logic [1:0] OPC_SPECIAL = 2'h0;
  localparam logic [1:0] OPC_WRITE = 2'h1;
  localparam logic [1:0] OPC_READ = 2'h2;
  localparam logic [1:0] OPC_ERASE = 2'h3;
  localparam logic [1:0] SEL_DISABLE = 2'h0;
  localparam logic [1:0] SEL_WRALL = 2'h1;
  localparam logic [1:0] SEL_ERALL = 2'h2;
  localparam logic [1:0] SEL_ENABLE = 2'h3;

  // ----------------------------------------
  // Organisation
  // ----------------------------------------
  localparam logic [4:0] ADDR_W_X8 = 5'h0b;
  localparam logic [4:0] ADDR_W_X16 = 5'h0a;
  localparam logic [4:0] DATA_W_X8 = 5'h08;
  localparam logic [4:0] DATA_W_X16 = 5'h10;
  localparam int WORD_COUNT = 1024;
  localparam logic [15:0] ERASED_WORD = 16'hffff;
  localparam logic [7:0] ERASED_BYTE = 8'hff;

  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int CLK_MHZ = 250;
  localparam int CS_LOW_MIN_NS = 250;
  localparam int CS_LOW_MIN_CYCLES = (CS_LOW_MIN_NS * CLK_MHZ + 999) / 1000;
  localparam int WRITE_CYCLE_MS = 10;
  localparam int WRITE_CYCLE_CYCLES = WRITE_CYCLE_MS * 1000 * CLK_MHZ;
  localparam int FIFO_DEPTH = 8;

  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_CMD = 3'h1,
    ST_DATA = 3'h3,
    ST_READ = 3'h2,
    ST_WAIT = 3'h6
  } ee_state_e;

  typedef enum logic [1:0] {
    PROG_WRITE = 2'h0,
    PROG_ERASE = 2'h1,
    PROG_WRALL = 2'h2,
    PROG_ERALL = 2'h3
  } ee_prog_op_e;

  typedef struct packed {
    ee_prog_op_e op;
    logic byteMode;
    logic [10:0] addr;
    logic [15:0] data;
  } ee_prog_cmd_s;

endpackage

// ---- core/ee_fifo.sv ----
// Parameterised valid/ready FIFO in flip-flops
`timescale 1ns/1ps
module ee_fifo
  import ee_pkg::*;
#(
  parameter int WIDTH = 30,
  parameter int DEPTH = FIFO_DEPTH
)
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // Fill side
  input wire logic inValid,
  output logic inReady,
  input wire logic [WIDTH-1:0] inData,
  // Drain side
  output logic outValid,
  input wire logic outReady,
  output logic [WIDTH-1:0] outData
);

  localparam int PW = $clog2(DEPTH);

  logic [WIDTH-1:0] store [DEPTH];
  logic [PW-1:0] wrPtr;
  logic [PW-1:0] rdPtr;
  logic [PW:0] count;
  logic push;
  logic pop;

  assign inReady = (count != (PW+1)'(DEPTH));
  assign outValid = (count != '0);
  assign push = inValid && inReady;
  assign pop = outValid && outReady;
  assign outData = store[rdPtr];

  always_ff @(posedge core_clk)
  begin
    if (push)
    begin
      store[wrPtr] <= inData;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      wrPtr <= '0;
      rdPtr <= '0;
      count <= '0;
    end
    else
    begin
      if (push)
      begin
        wrPtr <= (wrPtr == PW'(DEPTH - 1)) ? '0 : wrPtr + 1'b1;
      end
      if (pop)
      begin
        rdPtr <= (rdPtr == PW'(DEPTH - 1)) ? '0 : rdPtr + 1'b1;
      end
      count <= count + (PW+1)'(push) - (PW+1)'(pop);
    end
  end

endmodule // ee_fifo

// ---- core/ee_command_logic.sv ----
// Serial EEPROM instruction decoder, array and programming engine
`timescale 1ns/1ps
module ee_command_logic
  import ee_pkg::*;
#(
  parameter int WORDS = WORD_COUNT,
  parameter int PROG_CYCLES = WRITE_CYCLE_CYCLES,
  parameter int CS_MIN_CYCLES = CS_LOW_MIN_CYCLES,
  parameter int QUEUE_DEPTH = FIFO_DEPTH
)
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // Serial pins
  input wire logic chipSelect,
  input wire logic serial_clock_pin,
  input wire logic serial_in,
  output logic dataOut,
  output logic dataOutEn,
  // Straps
  input wire logic writeProtectN,
  input wire logic word_width_select,
  // Status
  output logic programEnabled,
  output logic programBusy
);

  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  localparam int CMD_W = $bits(ee_prog_cmd_s);
  localparam int CNT_W = $clog2(PROG_CYCLES + 1);
  localparam int LOW_W = $clog2(CS_MIN_CYCLES + 1);

  ee_state_e state;
  logic skPrev;
  logic csPrev;
  logic skRise;
  logic csFall;
  logic csRise;
  logic x16;
  logic [4:0] addrW;
  logic [4:0] dataW;
  logic [4:0] bitCnt;
  logic [12:0] cmdShift;
  logic [12:0] next_cmdShift;
  logic [1:0] opField;
  logic [1:0] selField;
  logic [10:0] addrField;
  logic [15:0] dataShift;
  logic [15:0] next_dataShift;
  ee_prog_cmd_s pendCmd;
  logic pending;
  logic [10:0] rdAddr;
  logic [15:0] rdShift;
  logic [4:0] rdCnt;
  logic doBit;
  logic readActive;
  logic [15:0] mem [WORDS];
  logic pushValid;
  logic pushReady;
  logic popValid;
  logic popReady;
  ee_prog_cmd_s popCmd;
  ee_prog_cmd_s activeCmd;
  logic engineBusy;
  logic [CNT_W-1:0] progCnt;
  logic progDone;
  logic busyAll;
  logic statusArm;
  logic statusShow;
  logic [LOW_W-1:0] csLowCnt;

  // ----------------------------------------
  // Functions
  // ----------------------------------------
  // Word for the read shifter, left aligned so bit 15 is always next out
  function automatic logic [15:0] readWord(input logic [10:0] a, input logic wide);
    logic [15:0] w;
    w = mem[a[10:1]];
    if (wide)
    begin
      readWord = mem[a[9:0]];
    end
    else
    begin
      readWord = a[0] ? {w[15:8], 8'h00} : {w[7:0], 8'h00};
    end
  endfunction

  // Next address, wrapping inside the active address width
  function automatic logic [10:0] wrapInc(input logic [10:0] a, input logic wide);
    logic [10:0] n;
    n = a + 11'h001;
    if (wide)
    begin
      n[10] = 1'b0;
    end
    wrapInc = n;
  endfunction

  // ----------------------------------------
  // Pin edges and organisation
  // ----------------------------------------
  assign skRise = serial_clock_pin && !skPrev;
  assign csFall = !chipSelect && csPrev;
  assign csRise = chipSelect && !csPrev;
  assign x16 = word_width_select;
  assign addrW = x16 ? ADDR_W_X16 : ADDR_W_X8;
  assign dataW = x16 ? DATA_W_X16 : DATA_W_X8;
  assign busyAll = engineBusy || popValid;
  assign programBusy = busyAll;

  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      skPrev <= 1'b0;
      csPrev <= 1'b0;
    end
    else
    begin
      skPrev <= serial_clock_pin;
      csPrev <= chipSelect;
    end
  end

  // ----------------------------------------
  // Field extraction
  // ----------------------------------------
  always_comb
  begin
    next_cmdShift = {cmdShift[11:0], serial_in};
    next_dataShift = {dataShift[14:0], serial_in};
    opField = x16 ? next_cmdShift[11:10] : next_cmdShift[12:11];
    addrField = x16 ? {1'b0, next_cmdShift[9:0]} : next_cmdShift[10:0];
    selField = x16 ? next_cmdShift[9:8] : next_cmdShift[10:9];
  end

  // ----------------------------------------
  // Instruction sequencer
  // ----------------------------------------
  // Nothing moves without a serial edge, so a parked clock freezes the frame
  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      state <= ST_IDLE;
      bitCnt <= '0;
      cmdShift <= '0;
      dataShift <= '0;
      pendCmd <= '0;
      pending <= 1'b0;
      programEnabled <= 1'b0;
      rdAddr <= '0;
      rdShift <= '0;
      rdCnt <= '0;
      doBit <= 1'b0;
      readActive <= 1'b0;
    end
    else if (!chipSelect)
    begin
      state <= ST_IDLE;
      pending <= 1'b0;
      readActive <= 1'b0;
      bitCnt <= '0;
    end
    else if (skRise)
    begin
      case (state)
        ST_IDLE:
        begin
          // Clocks before the start bit are don't care
          if (serial_in && !busyAll)
          begin
            state <= ST_CMD;
            bitCnt <= '0;
            cmdShift <= '0;
          end
        end
        ST_CMD:
        begin
          cmdShift <= next_cmdShift;
          bitCnt <= bitCnt + 5'h01;
          if (bitCnt == 5'(OPCODE_BITS) + addrW - 5'h01)
          begin
            bitCnt <= '0;
            pendCmd.byteMode <= !x16;
            pendCmd.addr <= addrField;
            pendCmd.data <= '0;
            case (opField)
              OPC_READ:
              begin
                // Read ignores the enable latch entirely
                rdAddr <= addrField;
                rdShift <= readWord(addrField, x16);
                rdCnt <= dataW;
                doBit <= 1'b0;
                readActive <= 1'b1;
                state <= ST_READ;
              end
              OPC_WRITE:
              begin
                pendCmd.op <= PROG_WRITE;
                state <= ST_DATA;
              end
              OPC_ERASE:
              begin
                pendCmd.op <= PROG_ERASE;
                pending <= 1'b1;
                state <= ST_WAIT;
              end
              default:
              begin
                case (selField)
                  SEL_ENABLE:
                  begin
                    programEnabled <= 1'b1;
                    state <= ST_WAIT;
                  end
                  SEL_DISABLE:
                  begin
                    programEnabled <= 1'b0;
                    state <= ST_WAIT;
                  end
                  SEL_WRALL:
                  begin
                    pendCmd.op <= PROG_WRALL;
                    state <= ST_DATA;
                  end
                  default:
                  begin
                    pendCmd.op <= PROG_ERALL;
                    pending <= 1'b1;
                    state <= ST_WAIT;
                  end
                endcase
              end
            endcase
          end
        end
        ST_DATA:
        begin
          dataShift <= next_dataShift;
          bitCnt <= bitCnt + 5'h01;
          if (bitCnt == dataW - 5'h01)
          begin
            pendCmd.data <= next_dataShift;
            pending <= 1'b1;
            state <= ST_WAIT;
          end
        end
        ST_READ:
        begin
          doBit <= rdShift[15];
          rdShift <= {rdShift[14:0], 1'b0};
          rdCnt <= rdCnt - 5'h01;
          if (rdCnt == 5'h01)
          begin
            rdAddr <= wrapInc(rdAddr, x16);
            rdShift <= readWord(wrapInc(rdAddr, x16), x16);
            rdCnt <= dataW;
          end
        end
        ST_WAIT:
        begin
          state <= ST_WAIT;
        end
        default:
        begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------
  // Hand-off to the programming queue
  // ----------------------------------------
  // Held instruction launches only on deselect; a refused one is dropped
  assign pushValid = csFall && pending && programEnabled && writeProtectN;

  ee_fifo #(
    .WIDTH(CMD_W),
    .DEPTH(QUEUE_DEPTH)
  ) u_queue (
    .core_clk(core_clk),
    .reset(reset),
    .inValid(pushValid),
    .inReady(pushReady),
    .inData(pendCmd),
    .outValid(popValid),
    .outReady(popReady),
    .outData(popCmd)
  );

  // ----------------------------------------
  // Programming engine
  // ----------------------------------------
  // Runs regardless of select, so a started cycle always finishes
  assign popReady = !engineBusy;
  assign progDone = engineBusy && (progCnt == '0);

  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      engineBusy <= 1'b0;
      progCnt <= '0;
      activeCmd <= '0;
    end
    else if (popValid && popReady)
    begin
      engineBusy <= 1'b1;
      progCnt <= CNT_W'(PROG_CYCLES - 1);
      activeCmd <= popCmd;
    end
    else if (engineBusy)
    begin
      progCnt <= progCnt - 1'b1;
      if (progDone)
      begin
        engineBusy <= 1'b0;
      end
    end
  end

  // Array has no reset: its contents are the nonvolatile state
  always_ff @(posedge core_clk)
  begin
    if (progDone)
    begin
      case (activeCmd.op)
        PROG_WRITE:
        begin
          if (!activeCmd.byteMode)
          begin
            mem[activeCmd.addr[9:0]] <= activeCmd.data;
          end
          else if (activeCmd.addr[0])
          begin
            mem[activeCmd.addr[10:1]][15:8] <= activeCmd.data[7:0];
          end
          else
          begin
            mem[activeCmd.addr[10:1]][7:0] <= activeCmd.data[7:0];
          end
        end
        PROG_ERASE:
        begin
          if (!activeCmd.byteMode)
          begin
            mem[activeCmd.addr[9:0]] <= ERASED_WORD;
          end
          else if (activeCmd.addr[0])
          begin
            mem[activeCmd.addr[10:1]][15:8] <= ERASED_BYTE;
          end
          else
          begin
            mem[activeCmd.addr[10:1]][7:0] <= ERASED_BYTE;
          end
        end
        PROG_WRALL:
        begin
          for (int i = 0; i < WORDS; i++)
          begin
            mem[i] <= activeCmd.byteMode ?
              {activeCmd.data[7:0], activeCmd.data[7:0]} : activeCmd.data;
          end
        end
        default:
        begin
          for (int i = 0; i < WORDS; i++)
          begin
            mem[i] <= ERASED_WORD;
          end
        end
      endcase
    end
  end

  // ----------------------------------------
  // Ready/busy polling
  // ----------------------------------------
  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      csLowCnt <= '0;
    end
    else if (chipSelect)
    begin
      csLowCnt <= '0;
    end
    else if (csLowCnt != LOW_W'(CS_MIN_CYCLES))
    begin
      csLowCnt <= csLowCnt + 1'b1;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      statusArm <= 1'b0;
      statusShow <= 1'b0;
    end
    else if (pushValid && pushReady)
    begin
      statusArm <= 1'b1;
      statusShow <= 1'b0;
    end
    else if (chipSelect && skRise && serial_in)
    begin
      statusArm <= 1'b0;
      statusShow <= 1'b0;
    end
    else if (csRise && statusArm && csLowCnt == LOW_W'(CS_MIN_CYCLES))
    begin
      statusShow <= 1'b1;
    end
    else if (!chipSelect)
    begin
      statusShow <= 1'b0;
    end
  end

  // ----------------------------------------
  // Serial output pin
  // ----------------------------------------
  // Registered for a clean pin; costs one core clock after the serial edge
  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      dataOut <= 1'b0;
      dataOutEn <= 1'b0;
    end
    else
    begin
      dataOut <= statusShow ? !busyAll : doBit;
      dataOutEn <= chipSelect && (readActive || statusShow);
    end
  end

endmodule // ee_command_logic

// ---- testbench/ee_command_logic_properties.sv ----
// Port-level checks on the command logic
`timescale 1ns/1ps
module ee_command_props
  import ee_pkg::*;
#(
  parameter int PROG_CYCLES = WRITE_CYCLE_CYCLES
)
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // Serial pins
  input wire logic chipSelect,
  input wire logic serial_clock_pin,
  input wire logic serial_in,
  input wire logic dataOut,
  input wire logic dataOutEn,
  // Straps and status
  input wire logic writeProtectN,
  input wire logic word_width_select,
  input wire logic programEnabled,
  input wire logic programBusy
);
  logic skPrev;
  logic skRise;
  int busyCnt;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);
  assign skRise = serial_clock_pin & ~skPrev;
  always_ff @(posedge core_clk)
  begin
    skPrev <= reset ? 1'b0 : serial_clock_pin;
  end
  // Length of the current busy stretch
  always_ff @(posedge core_clk)
  begin
    busyCnt <= programBusy ? busyCnt + 1 : 0;
  end
  reset_quiet_a: assert property (disable iff (1'b0) reset |=>
    !programEnabled && !programBusy && !dataOutEn) else $error("outputs active after reset");
  launch_gate_a: assert property ($rose(programBusy) |->
    $past(programEnabled) && $past(writeProtectN) && !$past(chipSelect))
    else $error("bad launch");
  busy_length_a: assert property ($fell(programBusy) |->
    busyCnt >= PROG_CYCLES) else $error("programming cycle cut short");
  read_dummy_a: assert property ($rose(dataOutEn) && $past(skRise, 2) |->
    !dataOut) else $error("no zero dummy bit");
  stall_hold_a: assert property (dataOutEn && $past(dataOutEn) && $past(chipSelect)
    && !$past(skRise, 2) && !$past(programBusy) && !$past(programBusy, 2) |-> $stable(dataOut))
    else $error("output moved without serial rise");
  status_busy_a: assert property (dataOutEn && $past(dataOutEn) && $past(programBusy)
    |-> !dataOut) else $error("ready shown while busy");
  latch_source_a: assert property ($changed(programEnabled) |->
    $past(chipSelect) && $past(skRise)) else $error("latch moved outside a frame");
  deselect_quiet_a: assert property (!chipSelect && !$past(chipSelect) |->
    !dataOutEn) else $error("output driven while deselected");
  cover property ($rose(programBusy));
  cover property ($rose(dataOutEn) && $past(skRise, 2));
  cover property ($fell(programEnabled));
endmodule // ee_command_props

bind ee_command_logic ee_command_props #(.PROG_CYCLES(PROG_CYCLES)) ee_command_props_i (
  .core_clk(core_clk), .reset(reset), .chipSelect(chipSelect),
  .serial_clock_pin(serial_clock_pin), .serial_in(serial_in), .dataOut(dataOut),
  .dataOutEn(dataOutEn), .writeProtectN(writeProtectN),
  .word_width_select(word_width_select), .programEnabled(programEnabled),
  .programBusy(programBusy));

// ---- testbench/ee_host_model.sv ----
// Host controller model driving the three serial pins
`timescale 1ns/1ps
module ee_host_model
  import ee_pkg::*;
(
  // Clock
  input wire logic core_clk,
  // Serial pins
  output logic chipSelect,
  output logic serial_clock_pin,
  output logic serial_in,
  input wire logic dataOut,
  input wire logic dataOutEn
);
  int stallCycles = 0;
  logic pinLevel;
  // Released pin has no pull, so show the inverse rather than a stale level
  assign pinLevel = dataOutEn ? dataOut : ~dataOut;
  initial
  begin
    chipSelect = 1'b0;
    serial_clock_pin = 1'b0;
    serial_in = 1'b0;
  end
  // Data set while the clock is low, held through the rise
  task automatic tick(input logic bitIn, output logic bitOut);
    serial_in = bitIn;
    repeat (2 + stallCycles) @(negedge core_clk);
    serial_clock_pin = 1'b1;
    repeat (2) @(negedge core_clk);
    bitOut = pinLevel;
    serial_clock_pin = 1'b0;
  endtask
  task automatic send(input logic [31:0] bits, input int n, output logic lastOut);
    chipSelect = 1'b1;
    for (int i = n - 1; i >= 0; i--)
      tick(bits[i], lastOut);
  endtask
  task automatic fetch(input int n, output logic [15:0] word);
    logic b;
    word = '0;
    for (int i = 0; i < n; i++)
    begin
      tick(1'b0, b);
      word = {word[14:0], b};
    end
  endtask
  // Clock stands low; data line flipped so a stale level is not trusted
  task automatic deselect();
    chipSelect = 1'b0;
    serial_in = ~serial_in;
    repeat (12) @(negedge core_clk);
  endtask
  task automatic poll(output logic first, output logic done);
    chipSelect = 1'b1;
    repeat (3) @(negedge core_clk);
    first = pinLevel;
    done = 1'b0;
    for (int i = 0; i < 200 && !done; i++)
    begin
      @(negedge core_clk);
      done = dataOutEn & pinLevel;
    end
    deselect();
  endtask
endmodule // ee_host_model

// ---- testbench/ee_command_logic_tb.sv ----
// Self-checking bench for the serial EEPROM command logic
`timescale 1ns/1ps
module ee_command_logic_tb;
  import ee_pkg::*;
  localparam int PROG = 40;
  logic core_clk, reset, writeProtectN, word_width_select;
  logic chipSelect, serial_clock_pin, serial_in, dataOut, dataOutEn;
  logic programEnabled, programBusy, last;
  logic pollFirst, pollDone;
  logic [15:0] word;
  int miscompares = 0;
  int testsRun = 0;
  ee_command_logic #(.PROG_CYCLES(PROG), .CS_MIN_CYCLES(4)) ee_command_logic_i (
    .core_clk(core_clk), .reset(reset), .chipSelect(chipSelect),
    .serial_clock_pin(serial_clock_pin), .serial_in(serial_in), .dataOut(dataOut),
    .dataOutEn(dataOutEn), .writeProtectN(writeProtectN),
    .word_width_select(word_width_select), .programEnabled(programEnabled),
    .programBusy(programBusy));
  ee_host_model ee_host_model_i (.core_clk(core_clk), .chipSelect(chipSelect),
    .serial_clock_pin(serial_clock_pin), .serial_in(serial_in), .dataOut(dataOut),
    .dataOutEn(dataOutEn));
  initial
  begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic check(input logic [15:0] seen, input logic [15:0] want);
    testsRun++;
    if (seen !== want)
    begin
      miscompares++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask
  task automatic finishTest();
    $display("compares %0d mismatches %0d", testsRun, miscompares);
    if (miscompares == 0 && testsRun > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic op16(input logic [1:0] op, input logic [9:0] a, input logic [15:0] d,
    input bit withData);
    if (withData)
      ee_host_model_i.send({3'h0, 1'b1, op, a, d}, 29, last);
    else
      ee_host_model_i.send({19'h0, 1'b1, op, a}, 13, last);
  endtask
  task automatic cmd(input logic [1:0] op, input logic [9:0] a, input logic [15:0] d,
    input bit withData);
    op16(op, a, d, withData);
    ee_host_model_i.deselect();
  endtask
  task automatic progWait();
    logic first, done;
    ee_host_model_i.poll(first, done);
    check(first, 1'b0);
    check(done, 1'b1);
    if (done !== 1'b1)
      finishTest();
  endtask
  task automatic waitIdle();
    for (int i = 0; i < 200 && programBusy !== 1'b0; i++)
      @(negedge core_clk);
    check(programBusy, 1'b0);
    if (programBusy !== 1'b0)
      finishTest();
  endtask
  task automatic readCheck(input logic [9:0] a, input logic [15:0] w0, input logic [15:0] w1);
    op16(OPC_READ, a, 16'h0, 0);
    check(last, 1'b0);
    check(dataOutEn, 1'b1);
    ee_host_model_i.fetch(16, word);
    check(word, w0);
    ee_host_model_i.fetch(16, word);
    check(word, w1);
    ee_host_model_i.deselect();
  endtask
  // ----------------------------------------
  // Sequence
  // ----------------------------------------
  initial
  begin
    reset = 1'b1;
    writeProtectN = 1'b1;
    word_width_select = 1'b1;
    repeat (2) @(negedge core_clk);
    reset = 1'b0;
    check(programEnabled, 1'b0);
    check(programBusy, 1'b0);
    cmd(OPC_WRITE, 10'h005, 16'h1111, 1);
    check(programBusy, 1'b0);
    cmd(OPC_SPECIAL, {SEL_ENABLE, 8'h00}, 16'h0, 0);
    check(programEnabled, 1'b1);
    $display("test latch done");
    cmd(OPC_SPECIAL, {SEL_ERALL, 8'h00}, 16'h0, 0);
    check(programBusy, 1'b1);
    progWait();
    readCheck(10'h001, 16'hffff, 16'hffff);
    // Disable sent while busy must be dropped
    cmd(OPC_WRITE, 10'h3ff, 16'ha5c3, 1);
    cmd(OPC_SPECIAL, {SEL_DISABLE, 8'h00}, 16'h0, 0);
    check(programEnabled, 1'b1);
    waitIdle();
    cmd(OPC_WRITE, 10'h000, 16'h0f0f, 1);
    progWait();
    ee_host_model_i.stallCycles = 30;
    readCheck(10'h3ff, 16'ha5c3, 16'h0f0f);
    ee_host_model_i.stallCycles = 0;
    $display("test write read done");
    word_width_select = 1'b0;
    ee_host_model_i.send({18'h0, 1'b1, OPC_READ, 11'h7ff}, 14, last);
    ee_host_model_i.fetch(8, word);
    check(word, 16'h00a5);
    ee_host_model_i.fetch(8, word);
    check(word, 16'h000f);
    ee_host_model_i.deselect();
    word_width_select = 1'b1;
    $display("test byte mode done");
    writeProtectN = 1'b0;
    cmd(OPC_SPECIAL, {SEL_WRALL, 8'h00}, 16'h1234, 1);
    check(programBusy, 1'b0);
    writeProtectN = 1'b1;
    cmd(OPC_SPECIAL, {SEL_WRALL, 8'h00}, 16'h1234, 1);
    progWait();
    cmd(OPC_ERASE, 10'h155, 16'h0, 0);
    progWait();
    cmd(OPC_SPECIAL, {SEL_DISABLE, 8'h00}, 16'h0, 0);
    check(programEnabled, 1'b0);
    cmd(OPC_ERASE, 10'h000, 16'h0, 0);
    check(programBusy, 1'b0);
    readCheck(10'h3ff, 16'h1234, 16'h1234);
    readCheck(10'h154, 16'h1234, 16'hffff);
    $display("test program ops done");
    // Clock with data high clears the flag; the start bit is refused while busy
    cmd(OPC_SPECIAL, {SEL_ENABLE, 8'h00}, 16'h0, 0);
    check(programEnabled, 1'b1);
    cmd(OPC_WRITE, 10'h002, 16'hbeef, 1);
    ee_host_model_i.send(32'h1, 1, last);
    check(dataOutEn, 1'b0);
    check(programBusy, 1'b1);
    ee_host_model_i.deselect();
    ee_host_model_i.poll(pollFirst, pollDone);
    check(pollDone, 1'b0);
    waitIdle();
    readCheck(10'h002, 16'hbeef, 16'h1234);
    $display("test status done");
    finishTest();
  end
endmodule // ee_command_logic_tb
